// [common/card_info_regs.vh]
// Constants of the card information table: byte values, attribute
// offsets, bus map of the slave, and the layout of its status word.
// Assumes inclusion by bare name from the design files only.
`ifndef CARD_INFO_REGS_VH
`define CARD_INFO_REGS_VH

// Bus map: attribute byte A sits at byte address 4*A
`define CIS_WIN_LAST 9'h146
`define CIS_WIN_FIRST 9'h0c0
`define CIS_CTRL_ADDR 12'h800
`define CIS_STAT_ADDR 12'h804
`define CIS_CTRL_START_BIT 0
`define CIS_STAT_BUSY_BIT 0
`define CIS_STAT_DONE_BIT 1
`define CIS_STAT_OVER_BIT 2
`define CIS_STAT_CNT_LSB 4
`define CIS_STAT_PTR_LSB 16
`define CIS_WALK_START 9'h0cc
`define CIS_ODD_FILL 8'h00

// Tuple codes and link lengths
`define CIS_CODE_CFTABLE 8'h1b
`define CIS_LINK_ALT 8'h06
`define CIS_LINK_FULL 8'h0f
`define CIS_CODE_NOLINK 8'h14
`define CIS_LINK_NONE 8'h00
`define CIS_CODE_END 8'hff

// Entry contents
`define CIS_IDX_ALT1 8'h01
`define CIS_IDX_ALT2 8'h02
`define CIS_IDX_ALT3 8'h03
`define CIS_IDX_DEF2 8'hc2
`define CIS_IDX_DEF3 8'hc3
`define CIS_IF_IO 8'h41
`define CIS_FS_IO 8'h99
`define CIS_FS_ALT 8'h01
`define CIS_PD_NOM 8'h01
`define CIS_PD_PEAK 8'h21
`define CIS_VOLT_5V0 8'h55
`define CIS_VOLT_MANT_X 8'hb5
`define CIS_VOLT_EXT_330 8'h1e
`define CIS_PEAK_45MA 8'h4d
`define CIS_IO_CONTIG 8'h64
`define CIS_IO_RANGED 8'hea
`define CIS_RANGE_FMT 8'h61
`define CIS_IRQ_MASKED 8'hf0
`define CIS_IRQ_MASK_ALL 8'hff
`define CIS_IRQ_14 8'hee
`define CIS_MISC 8'h20
`define CIS_PRI_BASE1_LO 8'hf0
`define CIS_PRI_BASE1_HI 8'h01
`define CIS_PRI_BASE2_LO 8'hf6
`define CIS_PRI_BASE2_HI 8'h03
`define CIS_SEC_BASE1_LO 8'h70
`define CIS_SEC_BASE1_HI 8'h01
`define CIS_SEC_BASE2_LO 8'h76
`define CIS_SEC_BASE2_HI 8'h03
`define CIS_LEN_8 8'h07
`define CIS_LEN_2 8'h01

`endif

// [core/card_info_rom.v]
// Card information table tail as a read-only AHB-Lite slave, plus a
// hardware tuple walker that software starts and watches.
// Assumes a single AHB-Lite master, word transfers, hready = hreadyout.
`timescale 1ns/10ps
`include "card_info_regs.vh"

// Function
// R01 - Contiguous entry: 8/16-bit hosts, four lines
// R02 - Contiguous interrupt byte F0h, two FFh masks
// R03 - Primary entry: ten lines, 1F0h and 3F6h
// R04 - Secondary entry: ranges 170h and 376h
// R05 - Primary and secondary request interrupt 14
// R06 - Default indexes C2h/C3h, alternates 01h-03h
// R07 - Interface byte 41h: I/O, ready/busy
// R08 - Feature byte 99h on default entries
// R09 - Misc byte 20h: power-down, read/write
// R10 - Entries open 1Bh, link 06h or 0Fh
// R11 - No-link 14h at 140h, FFh ends
// R12 - Alternates carry 3.30 V extension byte
// R13 - One byte per even attribute address
// R14 - Table writes ignored, table reads fixed always
// R15 - Host walks tuples by link, stops on FFh
module card_info_rom (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_WALK = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	// Fixed table; odd and unlisted addresses give the fill byte
	function [7:0] cis_byte;
		input [8:0] a;
		begin
			case (a)
				9'h0c0: cis_byte = `CIS_VOLT_5V0;
				9'h0c2: cis_byte = `CIS_IO_CONTIG; // see R01
				9'h0c4: cis_byte = `CIS_IRQ_MASKED; // see R02
				9'h0c6: cis_byte = `CIS_IRQ_MASK_ALL; // see R02
				9'h0c8: cis_byte = `CIS_IRQ_MASK_ALL; // see R02
				9'h0ca: cis_byte = `CIS_MISC; // see R09
				9'h0cc: cis_byte = `CIS_CODE_CFTABLE; // see R10
				9'h0ce: cis_byte = `CIS_LINK_ALT; // see R10
				9'h0d0: cis_byte = `CIS_IDX_ALT1; // see R06
				9'h0d2: cis_byte = `CIS_FS_ALT;
				9'h0d4: cis_byte = `CIS_PD_PEAK;
				9'h0d6: cis_byte = `CIS_VOLT_MANT_X; // see R12
				9'h0d8: cis_byte = `CIS_VOLT_EXT_330; // see R12
				9'h0da: cis_byte = `CIS_PEAK_45MA;
				9'h0dc: cis_byte = `CIS_CODE_CFTABLE; // see R10
				9'h0de: cis_byte = `CIS_LINK_FULL; // see R10
				9'h0e0: cis_byte = `CIS_IDX_DEF2; // see R06
				9'h0e2: cis_byte = `CIS_IF_IO; // see R07
				9'h0e4: cis_byte = `CIS_FS_IO; // see R08
				9'h0e6: cis_byte = `CIS_PD_NOM;
				9'h0e8: cis_byte = `CIS_VOLT_5V0;
				9'h0ea: cis_byte = `CIS_IO_RANGED; // see R03
				9'h0ec: cis_byte = `CIS_RANGE_FMT; // see R03
				9'h0ee: cis_byte = `CIS_PRI_BASE1_LO; // see R03
				9'h0f0: cis_byte = `CIS_PRI_BASE1_HI; // see R03
				9'h0f2: cis_byte = `CIS_LEN_8; // see R03
				9'h0f4: cis_byte = `CIS_PRI_BASE2_LO; // see R03
				9'h0f6: cis_byte = `CIS_PRI_BASE2_HI; // see R03
				9'h0f8: cis_byte = `CIS_LEN_2; // see R03
				9'h0fa: cis_byte = `CIS_IRQ_14; // see R05
				9'h0fc: cis_byte = `CIS_MISC; // see R09
				9'h0fe: cis_byte = `CIS_CODE_CFTABLE; // see R10
				9'h100: cis_byte = `CIS_LINK_ALT; // see R10
				9'h102: cis_byte = `CIS_IDX_ALT2; // see R06
				9'h104: cis_byte = `CIS_FS_ALT;
				9'h106: cis_byte = `CIS_PD_PEAK;
				9'h108: cis_byte = `CIS_VOLT_MANT_X; // see R12
				9'h10a: cis_byte = `CIS_VOLT_EXT_330; // see R12
				9'h10c: cis_byte = `CIS_PEAK_45MA;
				9'h10e: cis_byte = `CIS_CODE_CFTABLE; // see R10
				9'h110: cis_byte = `CIS_LINK_FULL; // see R10
				9'h112: cis_byte = `CIS_IDX_DEF3; // see R06
				9'h114: cis_byte = `CIS_IF_IO; // see R07
				9'h116: cis_byte = `CIS_FS_IO; // see R08
				9'h118: cis_byte = `CIS_PD_NOM;
				9'h11a: cis_byte = `CIS_VOLT_5V0;
				9'h11c: cis_byte = `CIS_IO_RANGED; // see R04
				9'h11e: cis_byte = `CIS_RANGE_FMT; // see R04
				9'h120: cis_byte = `CIS_SEC_BASE1_LO; // see R04
				9'h122: cis_byte = `CIS_SEC_BASE1_HI; // see R04
				9'h124: cis_byte = `CIS_LEN_8; // see R04
				9'h126: cis_byte = `CIS_SEC_BASE2_LO; // see R04
				9'h128: cis_byte = `CIS_SEC_BASE2_HI; // see R04
				9'h12a: cis_byte = `CIS_LEN_2; // see R04
				9'h12c: cis_byte = `CIS_IRQ_14; // see R05
				9'h12e: cis_byte = `CIS_MISC; // see R09
				9'h130: cis_byte = `CIS_CODE_CFTABLE; // see R10
				9'h132: cis_byte = `CIS_LINK_ALT; // see R10
				9'h134: cis_byte = `CIS_IDX_ALT3; // see R06
				9'h136: cis_byte = `CIS_FS_ALT;
				9'h138: cis_byte = `CIS_PD_PEAK;
				9'h13a: cis_byte = `CIS_VOLT_MANT_X; // see R12
				9'h13c: cis_byte = `CIS_VOLT_EXT_330; // see R12
				9'h13e: cis_byte = `CIS_PEAK_45MA;
				9'h140: cis_byte = `CIS_CODE_NOLINK; // see R11
				9'h142: cis_byte = `CIS_LINK_NONE; // see R11
				9'h144: cis_byte = `CIS_CODE_END; // see R11
				9'h146: cis_byte = `CIS_CODE_END; // see R11
				default: cis_byte = `CIS_ODD_FILL; // see R13
			endcase
		end
	endfunction

	// Bus state
	reg wr_pend_q;
	reg wr_pend_d;
	reg [11:0] wr_addr_q;
	reg [11:0] wr_addr_d;
	reg [31:0] rdata_d;
	wire accept;
	wire start_walk;

	// Walker state
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [8:0] ptr_q;
	reg [8:0] ptr_d;
	reg [3:0] cnt_q;
	reg [3:0] cnt_d;
	reg over_q;
	reg over_d;
	reg [7:0] code_w;
	reg [7:0] link_w;
	reg [9:0] next_w;
	wire [31:0] status_w;

	assign accept = hsel & htrans[1] & hready;
	// Walk is triggered by the data phase of a write to the control word
	assign start_walk = wr_pend_q & (wr_addr_q == `CIS_CTRL_ADDR)
		& hwdata[`CIS_CTRL_START_BIT];

	assign status_w = {7'h00, ptr_q, 8'h00, cnt_q, 1'b0, over_q,
		state_q[2], state_q[1]};

	// Read data is chosen in the address phase so no wait state is needed
	always @* begin
		rdata_d = 32'h0000_0000;
		wr_pend_d = accept & hwrite & (haddr[31:12] == 20'h00000);
		wr_addr_d = haddr[11:0];
		if (accept & ~hwrite & (haddr[31:12] == 20'h00000)) begin
			if (haddr[11:2] <= {1'b0, `CIS_WIN_LAST}) begin
				rdata_d = {24'h000000, cis_byte(haddr[10:2])}; // see R13
			end else if (haddr[11:0] == `CIS_STAT_ADDR) begin
				rdata_d = status_w;
			end
		end
	end

	// Table bytes are constants, so writes to them fall on nothing
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end else begin
			hrdata <= rdata_d; // see R14
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
		end
	end

	// Tuple walk: code, then link, then skip by the link length
	always @* begin
		state_d = state_q;
		ptr_d = ptr_q;
		cnt_d = cnt_q;
		over_d = over_q;
		code_w = cis_byte(ptr_q);
		link_w = cis_byte(ptr_q + 9'h002);
		next_w = {1'b0, ptr_q} + {1'b0, link_w, 1'b0} + 10'h004; // see R15
		case (state_q)
			ST_WALK: begin
				if (code_w == `CIS_CODE_END) begin
					state_d = ST_DONE; // see R15
				end else begin
					cnt_d = cnt_q + 4'h1;
					if (next_w > {1'b0, `CIS_WIN_LAST}) begin
						// Link runs past the table end: stop and flag it
						over_d = 1'b1;
						state_d = ST_DONE;
					end else begin
						ptr_d = next_w[8:0];
					end
				end
			end
			default: begin
				state_d = state_q;
			end
		endcase
		if (start_walk) begin
			state_d = ST_WALK;
			ptr_d = `CIS_WALK_START;
			cnt_d = 4'h0;
			over_d = 1'b0;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			ptr_q <= `CIS_WALK_START;
			cnt_q <= 4'h0;
			over_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ptr_q <= ptr_d;
			cnt_q <= cnt_d;
			over_q <= over_d;
		end
	end

endmodule // card_info_rom

// [dv/card_info_rom_sva.sv]
// Checker of the table slave: fixed bytes, steady OKAY answer.
// Assumes it sees only slave ports, bound below.
`timescale 1ns/10ps
module card_info_rom_sva (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Read taken at this edge
	wire rd = hsel & htrans[1] & hready & ~hwrite;
	a_bus_okay: assert property (hreadyout && !hresp) else $error("answer");
	a_upper_zero: assert property (rd && haddr < 32'h51c |=> hrdata[31:8] == 24'h0)
		else $error("upper");
	a_odd_zero: assert property (rd && haddr[2] && haddr < 32'h51c |=> hrdata == 32'h0)
		else $error("odd");
	a_contig_io: assert property (rd && haddr == 32'h308 |=> hrdata[7:0] == 8'h64)
		else $error("io");
	a_pri_base: assert property (rd && haddr == 32'h3b8 |-> ##1 hrdata[7:0] == 8'hf0)
		else $error("base");
	a_irq_fourteen: assert property (rd && haddr == 32'h3e8 |=> hrdata[7:0] == 8'hee)
		else $error("irq");
	a_entry_code: assert property (rd && haddr == 32'h330 |=> hrdata[7:0] == 8'h1b)
		else $error("entry");
	a_end_marker: assert property (rd && haddr == 32'h518 |=> hrdata[7:0] == 8'hff)
		else $error("end");
	c_end_read: cover property (rd && haddr == 32'h518);
	c_walk_go: cover property (hsel && htrans[1] && hwrite && haddr == 32'h800);
	c_status: cover property (rd && haddr == 32'h804);
endmodule // card_info_rom_sva
bind card_info_rom card_info_rom_sva u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp));

// [dv/ahb_host.sv]
// Host socket model: single AHB-Lite word transfers.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
module ahb_host (
	input wire hclk,
	input wire hready,
	input wire [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// Quiet bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// Bounded wait, a hang ends the run
	task wait_ready;
		int n;
		begin
			n = 0;
			do begin
				@(posedge hclk);
				n++;
			end while (hready !== 1'b1 && n < 16);
			if (hready !== 1'b1) begin
				tb.failures++;
				tb.tally_and_finish();
			end
		end
	endtask
	// One word transfer, entered just after a rising edge
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		begin
			hsel <= 1'b1;
			haddr <= a;
			htrans <= 2'h2;
			hwrite <= w;
			wait_ready();
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			wait_ready();
			r = hrdata;
			hwdata <= ~d; // Released data must not look valid
		end
	endtask
endmodule // ahb_host

// [dv/tb.sv]
// Bench: table slave driven by the host model.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/10ps
module tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int failures, checks_done;
	logic [19:0] tbl [0:25] = '{20'h0c264, 20'h0c4f0, 20'h0c6ff, 20'h0eaea, 20'h0eef0,
		20'h0f001, 20'h0f207, 20'h0f4f6, 20'h0f603, 20'h12070, 20'h12803, 20'h0faee,
		20'h12cee, 20'h0e0c2, 20'h112c3, 20'h10202, 20'h0e241, 20'h0e499, 20'h0fc20,
		20'h0de0f, 20'h10006, 20'h14014, 20'h14200, 20'h0d6b5, 20'h0d81e, 20'h0c300};
	card_info_rom u_card_info_rom (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	ahb_host u_ahb_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// 40 MHz clock
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task rd_attr(input logic [8:0] a, output logic [31:0] r);
		u_ahb_host.xfer(1'b0, {21'h0, a, 2'b00}, 32'h0, r);
	endtask
	task t_table;
		foreach (tbl[i]) begin
			rd_attr(tbl[i][16:8], rd);
			chk("table byte", {24'h0, tbl[i][7:0]}, rd);
		end
		$display("table test done");
	endtask
	task t_walk;
		logic [8:0] p;
		logic [31:0] c;
		int n;
		begin
			p = 9'h0cc;
			n = 0;
			rd_attr(p, c);
			while (c[7:0] !== 8'hff && n < 16) begin
				rd_attr(p + 9'h2, rd);
				p = p + 9'h4 + {rd[7:0], 1'b0};
				n++;
				rd_attr(p, c);
			end
			chk("tuples", 32'd6, n);
			chk("end ptr", 32'h144, {23'h0, p});
			u_ahb_host.xfer(1'b1, 32'h800, 32'h1, rd);
			n = 0;
			do begin
				u_ahb_host.xfer(1'b0, 32'h804, 32'h0, rd);
				n++;
			end while (rd[1] !== 1'b1 && n < 16);
			chk("walk status", 32'h01440062, rd & 32'h01ff00f7);
			$display("walk test done");
		end
	endtask
	task t_write;
		u_ahb_host.xfer(1'b1, 32'h308, 32'hffffffff, rd);
		u_ahb_host.xfer(1'b1, 32'h600, 32'h12345678, rd);
		rd_attr(9'h0c2, rd);
		chk("after write", 32'h64, rd);
		u_ahb_host.xfer(1'b0, 32'h600, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_attr(9'h146, rd);
		chk("after reset", 32'hff, rd);
		$display("write test done");
	endtask
	task tally_and_finish;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence
	initial begin
		failures = 0;
		checks_done = 0;
		hresetn = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_table();
		t_walk();
		t_write();
		tally_and_finish();
	end
endmodule // tb
